// *** hdl/ebt_pkg.sv ***
// Constants, enumerations and timing figures for the external bus timing unit
package ebt_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and deadlock timeout
  localparam int CLK_NS = 25;
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
  // Margin must stay above zero and below one refresh interval
  localparam int MARGIN_CYC = REFRESH_CYC / 2;
  localparam int TIMEOUT_CYC = REFRESH_CYC + MARGIN_CYC;

  //////////////////////////////////////////////////////////////////////////////
  // Access periods in bus clocks
  localparam logic [3:0] ROM_SLOWEST = 4'h9;
  localparam logic [3:0] PAGE_SLOWEST = 4'h3;
  localparam logic [3:0] SYS_SLOWEST = 4'h8;
  localparam logic [3:0] FAST_SLOWEST = 4'h8;
  localparam logic [3:0] LCD_SLOWEST = 4'h8;
  localparam logic [3:0] FLASH_CYC = 4'h6;
  localparam logic [3:0] TAIL_CYC = 4'h3;
  localparam logic [1:0] PAGE_RFU_CODE = 2'h3;
  localparam logic [2:0] SYS_LAST_CODE = 3'h5;
  localparam logic [2:0] LCD_LAST_CODE = 3'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode on the upper physical address bits
  localparam logic [7:0] WIN_TOP8 = 8'h0A;
  localparam logic [5:0] RSV_HI_TOP6 = 6'h03;
  localparam logic [7:0] RSV_LO_FIRST8 = 8'h04;
  localparam logic [7:0] RSV_LO_LAST8 = 8'h09;
  localparam logic [6:0] ROM_TOP7 = 7'h0F;
  localparam logic [5:0] ISA_MEM_TOP6 = 6'h04;
  localparam logic [5:0] ISA_IO_TOP6 = 6'h05;
  localparam logic [4:0] MAX_SIZE = 5'h10;

  //////////////////////////////////////////////////////////////////////////////
  // Pin values outside a cycle
  localparam logic [3:0] SEL_IDLE = 4'hF;
  localparam logic [3:0] LANE_IDLE = 4'hF;

  typedef enum logic [2:0] {
    S_IDLE, S_ROM, S_FLASH, S_CMD, S_DATA, S_TAIL, S_LCD, S_HOLD
  } ebt_state_type;

  typedef enum logic [2:0] {
    K_ROM, K_PAGE, K_FLASH, K_ISAIO, K_ISAMEM, K_FAST, K_LCD
  } ebt_kind_type;

endpackage

// *** hdl/ebt_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** hdl/ebt_bus_unit.sv ***
// Bus control unit sequencing ROM, system bus, fast window and panel accesses
//
// Behaviour
// - Panel window data inverted both ways when space select and graphics bit are zero.
// - Panel window accepts one, two, four or eight byte accesses.
// - Wide mode plus panel wide enable gives 32-bit panel path with lane strobes.
// - Illegal read raises bus error; illegal write sets write error flag on irq zero.
// - No ready within refresh interval plus margin is a deadlock and illegal access.
// - Accesses to both reserved physical ranges are illegal.
// - Writing one to error status bit one clears the write error source.
// - Flash enable and page select choose ordinary, page or flash ROM cycles.
// - ROM wait code 000 to 111 gives 9 down to 2 clocks.
// - ROM accesses wider than the data bus (two or four bytes) repeat the period; data sampled after last clock.
// - Ordinary ROM supports 1, 2, 3 byte and 1, 2, 4 word reads.
// - Page wait code gives 3, 2, 1 clocks; ROM select and read stay low.
// - Flash mode uses fixed timing and permits writes and register reads.
// - System bus wait code 000 to 101 gives 8 down to 3 clocks.
// - Never both high byte enable and bit zero high; odd write copies byte down.
// - Channel ready sampled one period after strobe; ready adds one data period.
// - After ready high, 16-bit select sampled during the following period.
// - Zero wait sampled each clock from second period; low ends after three clocks.
// - Space select set makes window a fast system bus with panel select.
// - Space select clear makes window the panel port with 8, 6, 4, 2 clocks.
// - Hold request outside hibernate grants bus and floats outputs.
`timescale 1ns/1ps
module ebt_bus_unit #(
  parameter int TIMEOUT_CYCLES = ebt_pkg::TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [4:0] req_size,
  input wire logic [31:0] beat_wdata,
  output logic req_ready,
  output logic beat_done,
  output logic [31:0] beat_rdata,
  output logic access_done,
  output logic cmd_bus_error,
  output logic write_error_flag,
  output logic maskable_irq_line_zero,
  input wire logic error_status_write,
  input wire logic [31:0] error_status_wdata,
  input wire logic window_space_select,
  input wire logic graphics_mode_bit,
  input wire logic panel_wide_bus_enable,
  input wire logic wide_data_bus_mode,
  input wire logic flash_write_enable,
  input wire logic page_read_select,
  input wire logic [2:0] rom_wait_field,
  input wire logic [1:0] page_wait_field,
  input wire logic [2:0] sysbus_wait_field,
  input wire logic [2:0] fastbus_wait_field,
  input wire logic hibernate_mode,
  input wire logic [31:0] data_in,
  input wire logic iochrdy,
  input wire logic iocs16_n,
  input wire logic memcs16_n,
  input wire logic zero_wait_n,
  input wire logic hold_request_n,
  output logic [25:0] ext_addr,
  output logic [31:0] data_out,
  output logic data_oe,
  output logic bus_oe,
  output logic [3:0] rom_select_n,
  output logic rd_n,
  output logic wr_n,
  output logic ior_n,
  output logic iow_n,
  output logic memr_n,
  output logic memw_n,
  output logic panel_chip_select_n,
  output logic high_byte_enable_n,
  output logic address_bit_zero,
  output logic lane3_strobe_n,
  output logic lane2_strobe_n,
  output logic lane1_strobe_n,
  output logic lane0_strobe_n,
  output logic hold_grant_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Read data bypasses them: the access period settles it, and a two-stage pipe
  // would take it two clocks before the period's closing edge
  logic [4:0] ctl_s;

  ebt_sync #(.W(5), .INIT(5'h1E)) u_sync_ctl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({hold_request_n, zero_wait_n, memcs16_n, iocs16_n, iochrdy}),
    .sync_out(ctl_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Period lookups
  function automatic logic [3:0] sys_period(input logic [2:0] code);
    // Reserved codes fall back to the slowest setting
    if (code > ebt_pkg::SYS_LAST_CODE) begin
      return ebt_pkg::SYS_SLOWEST;
    end
    return ebt_pkg::SYS_SLOWEST - {1'b0, code};
  endfunction

  function automatic logic [3:0] lcd_period(input logic [2:0] code);
    if (code > ebt_pkg::LCD_LAST_CODE) begin
      return ebt_pkg::LCD_SLOWEST;
    end
    return ebt_pkg::LCD_SLOWEST - {code, 1'b0};
  endfunction

  function automatic logic [3:0] page_period(input logic [1:0] code);
    if (code == ebt_pkg::PAGE_RFU_CODE) begin
      return ebt_pkg::PAGE_SLOWEST;
    end
    return ebt_pkg::PAGE_SLOWEST - {2'b00, code};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    ebt_pkg::ebt_state_type st;
    ebt_pkg::ebt_kind_type kind;
    logic wr;
    logic first;
    logic cs16;
    logic [4:0] rem;
    logic [25:0] addr;
    logic [3:0] cnt;
    logic [15:0] tmo;
    logic ready;
    logic beat;
    logic [31:0] rdata;
    logic done;
    logic rd_err;
    logic wr_err;
    logic [3:0] rom_sel_n;
    logic rd_n;
    logic wr_n;
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
    logic pcs_n;
    logic shb_n;
    logic a0;
    logic [3:0] lane_n;
    logic [31:0] dout;
    logic doe;
    logic boe;
    logic grant_n;
  } ebt_regs_type;

  ebt_regs_type q;
  ebt_regs_type d;

  logic hold_rq;
  logic zws_low;
  logic cs_low;
  logic invert;
  logic wide_lcd;
  logic [2:0] bw;
  logic [2:0] nb;
  logic [3:0] lanes;
  logic [31:0] rv;
  logic [15:0] hw;
  logic fin;
  logic illegal;
  logic [7:0] top8;
  logic [3:0] rom_p;
  logic [3:0] next_p;

  assign hold_rq = !ctl_s[4];
  assign zws_low = !ctl_s[3];
  assign cs_low = (q.kind == ebt_pkg::K_ISAIO) ? !ctl_s[1] : !ctl_s[2];
  assign invert = !window_space_select && !graphics_mode_bit;
  assign wide_lcd = wide_data_bus_mode && panel_wide_bus_enable;
  assign top8 = req_addr[31:24];
  assign rom_p = ebt_pkg::ROM_SLOWEST - {1'b0, rom_wait_field};

  always_comb begin
    d = q;
    d.beat = 1'b0;
    d.done = 1'b0;
    d.rd_err = 1'b0;
    fin = 1'b0;
    illegal = 1'b0;
    next_p = rom_p;
    // Bytes this beat: limited by the bus width and the address alignment
    unique case (q.kind)
      ebt_pkg::K_ROM, ebt_pkg::K_PAGE, ebt_pkg::K_FLASH: bw = wide_data_bus_mode ? 3'h4 : 3'h2;
      ebt_pkg::K_LCD: bw = wide_lcd ? 3'h4 : 3'h2;
      default: bw = 3'h2;
    endcase
    nb = bw - ((bw == 3'h4) ? {1'b0, q.addr[1:0]} : {2'b00, q.addr[0]});
    if ({2'b00, nb} > q.rem) begin
      nb = q.rem[2:0];
    end
    if (q.st == ebt_pkg::S_DATA || q.st == ebt_pkg::S_TAIL) begin
      // An 8-bit target moves one byte per beat on the lower lane
      if (!q.cs16) begin
        nb = 3'h1;
      end
    end
    rv = (q.kind == ebt_pkg::K_LCD && invert) ? ~data_in : data_in;
    // Software clear; the hardware set below wins in the same cycle
    if (error_status_write && error_status_wdata[1]) begin
      d.wr_err = 1'b0;
    end
    unique case (q.st)
      ebt_pkg::S_IDLE: begin
        d.ready = 1'b1;
        if (hold_rq && !hibernate_mode) begin
          d.st = ebt_pkg::S_HOLD;
          d.ready = 1'b0;
        end else if (q.ready && req_valid) begin
          d.wr = req_write;
          d.rem = req_size;
          d.addr = req_addr[25:0];
          d.first = 1'b1;
          d.tmo = 16'h0000;
          d.ready = 1'b0;
          if (req_addr[31:26] == ebt_pkg::RSV_HI_TOP6 ||
              (top8 >= ebt_pkg::RSV_LO_FIRST8 && top8 <= ebt_pkg::RSV_LO_LAST8)) begin
            illegal = 1'b1;
          end else if (top8 == ebt_pkg::WIN_TOP8) begin
            if (window_space_select) begin
              d.kind = ebt_pkg::K_FAST;
              d.st = ebt_pkg::S_CMD;
              d.cnt = (ebt_pkg::FAST_SLOWEST - {1'b0, fastbus_wait_field}) - 4'h1;
              illegal = (req_size == 5'h3) || (req_size > 5'h8) || (req_size == 5'h0);
            end else begin
              d.kind = ebt_pkg::K_LCD;
              d.st = ebt_pkg::S_LCD;
              d.cnt = lcd_period(fastbus_wait_field) - 4'h1;
              illegal = !(req_size == 5'h1 || req_size == 5'h2 ||
                          req_size == 5'h4 || req_size == 5'h8);
            end
          end else if (req_addr[31:26] == ebt_pkg::ISA_MEM_TOP6 ||
                       req_addr[31:26] == ebt_pkg::ISA_IO_TOP6) begin
            d.kind = (req_addr[31:26] == ebt_pkg::ISA_IO_TOP6) ? ebt_pkg::K_ISAIO :
                                                                 ebt_pkg::K_ISAMEM;
            d.st = ebt_pkg::S_CMD;
            d.cnt = sys_period(sysbus_wait_field) - 4'h1;
            illegal = (req_size == 5'h3) || (req_size == 5'h0) || (req_size > ebt_pkg::MAX_SIZE);
          end else if (req_addr[31:25] == ebt_pkg::ROM_TOP7) begin
            illegal = (req_size == 5'h0) || (req_size > ebt_pkg::MAX_SIZE);
            if (flash_write_enable) begin
              d.kind = ebt_pkg::K_FLASH;
              d.st = ebt_pkg::S_FLASH;
              d.cnt = ebt_pkg::FLASH_CYC - 4'h1;
            end else begin
              d.kind = page_read_select ? ebt_pkg::K_PAGE : ebt_pkg::K_ROM;
              d.st = ebt_pkg::S_ROM;
              d.cnt = rom_p - 4'h1;
              // Writes outside flash mode finish without a write strobe
              if (req_write) begin
                d.st = ebt_pkg::S_IDLE;
                d.done = !illegal;
                d.ready = 1'b1;
              end
            end
          end else begin
            illegal = 1'b1;
          end
          if (illegal) begin
            d.st = ebt_pkg::S_IDLE;
          end
        end
      end
      ebt_pkg::S_HOLD: begin
        if (!hold_rq) begin
          d.st = ebt_pkg::S_IDLE;
        end
      end
      ebt_pkg::S_ROM, ebt_pkg::S_FLASH: begin
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else begin
          fin = 1'b1;
          next_p = (q.kind == ebt_pkg::K_PAGE) ? page_period(page_wait_field) :
                   (q.kind == ebt_pkg::K_FLASH) ? ebt_pkg::FLASH_CYC : rom_p;
        end
      end
      ebt_pkg::S_CMD: begin
        d.tmo = q.tmo + 16'h0001;
        next_p = (q.kind == ebt_pkg::K_FAST) ?
                 (ebt_pkg::FAST_SLOWEST - {1'b0, fastbus_wait_field}) :
                 sys_period(sysbus_wait_field);
        if (!q.first && zws_low) begin
          d.st = ebt_pkg::S_TAIL;
          d.cnt = ebt_pkg::TAIL_CYC - 4'h1;
          d.cs16 = cs_low;
        end else if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else if (ctl_s[0]) begin
          d.st = ebt_pkg::S_DATA;
          d.cnt = ((next_p < ebt_pkg::TAIL_CYC) ? ebt_pkg::TAIL_CYC : next_p) - 4'h1;
          d.cs16 = cs_low;
        end else begin
          d.cnt = next_p - 4'h1;
          d.first = 1'b0;
        end
      end
      ebt_pkg::S_DATA, ebt_pkg::S_TAIL: begin
        if (q.st == ebt_pkg::S_DATA) begin
          d.cs16 = q.cs16 | cs_low;
        end
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else begin
          fin = 1'b1;
          next_p = (q.kind == ebt_pkg::K_FAST) ?
                   (ebt_pkg::FAST_SLOWEST - {1'b0, fastbus_wait_field}) :
                   sys_period(sysbus_wait_field);
        end
      end
      ebt_pkg::S_LCD: begin
        d.tmo = q.tmo + 16'h0001;
        next_p = lcd_period(fastbus_wait_field);
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else if (ctl_s[0]) begin
          fin = 1'b1;
        end else begin
          d.cnt = next_p - 4'h1;
        end
      end
    endcase
    if ((q.st == ebt_pkg::S_CMD || q.st == ebt_pkg::S_LCD) &&
        q.tmo == 16'(TIMEOUT_CYCLES - 1) && !fin) begin
      illegal = 1'b1;
      d.st = ebt_pkg::S_IDLE;
    end
    if (fin) begin
      d.beat = 1'b1;
      if (bw == 3'h4 && (q.kind != ebt_pkg::K_LCD || wide_lcd)) begin
        d.rdata = rv;
      end else if (nb == 3'h1 && !q.cs16 && (q.st == ebt_pkg::S_DATA || q.st == ebt_pkg::S_TAIL)) begin
        d.rdata[{q.addr[1:0], 3'b000} +: 8] = rv[7:0];
      end else begin
        d.rdata[{q.addr[1], 4'h0} +: 16] = rv[15:0];
      end
      d.addr = q.addr + {23'h000000, nb};
      d.rem = q.rem - {2'b00, nb};
      d.first = 1'b0;
      d.tmo = 16'h0000;
      d.cnt = next_p - 4'h1;
      d.st = (q.st == ebt_pkg::S_DATA || q.st == ebt_pkg::S_TAIL) ? ebt_pkg::S_CMD : q.st;
      d.first = !(q.st == ebt_pkg::S_ROM || q.st == ebt_pkg::S_FLASH);
      if (q.rem == {2'b00, nb}) begin
        d.st = ebt_pkg::S_IDLE;
        d.done = 1'b1;
      end
    end
    if (illegal) begin
      d.done = 1'b1;
      d.ready = 1'b1;
      if (d.wr) begin
        d.wr_err = 1'b1;
      end else begin
        d.rd_err = 1'b1;
      end
    end
    // Pin drive follows the next state so strobes and lanes change together
    d.rom_sel_n = ebt_pkg::SEL_IDLE;
    d.rd_n = 1'b1;
    d.wr_n = 1'b1;
    d.ior_n = 1'b1;
    d.iow_n = 1'b1;
    d.memr_n = 1'b1;
    d.memw_n = 1'b1;
    d.pcs_n = 1'b1;
    d.shb_n = 1'b1;
    d.a0 = 1'b0;
    d.lane_n = ebt_pkg::LANE_IDLE;
    d.doe = 1'b0;
    d.boe = (d.st != ebt_pkg::S_HOLD);
    d.grant_n = (d.st != ebt_pkg::S_HOLD);
    lanes = 4'h0;
    hw = beat_wdata[{d.addr[1], 4'h0} +: 16];
    if (d.st != ebt_pkg::S_IDLE && d.st != ebt_pkg::S_HOLD) begin
      d.doe = d.wr;
      // Lower lane copy of the upper byte serves both odd 16-bit and 8-bit targets
      d.dout = {16'h0000, d.addr[0] ? {hw[15:8], hw[15:8]} : hw};
      d.a0 = d.addr[0];
      d.shb_n = !(d.addr[0] || d.rem > 5'h1);
    end
    unique case (d.st)
      ebt_pkg::S_ROM, ebt_pkg::S_FLASH: begin
        d.rom_sel_n = ~(4'h1 << d.addr[24:23]);
        d.rd_n = d.wr;
        d.wr_n = !(d.wr && d.kind == ebt_pkg::K_FLASH);
        if (wide_data_bus_mode) begin
          d.dout = beat_wdata;
        end
      end
      ebt_pkg::S_CMD, ebt_pkg::S_DATA, ebt_pkg::S_TAIL: begin
        d.ior_n = !(d.kind == ebt_pkg::K_ISAIO && !d.wr);
        d.iow_n = !(d.kind == ebt_pkg::K_ISAIO && d.wr);
        d.memr_n = !(d.kind != ebt_pkg::K_ISAIO && !d.wr);
        d.memw_n = !(d.kind != ebt_pkg::K_ISAIO && d.wr);
        d.pcs_n = (d.kind != ebt_pkg::K_FAST);
      end
      ebt_pkg::S_LCD: begin
        d.pcs_n = 1'b0;
        d.rd_n = d.wr;
        d.wr_n = !d.wr;
        if (wide_lcd) begin
          for (int i = 0; i < 4; i++) begin
            lanes[i] = (3'(i) >= {1'b0, d.addr[1:0]}) &&
                       ({2'b00, 3'(i)} < {3'b000, d.addr[1:0]} + d.rem);
          end
          d.lane_n = ~lanes;
          d.shb_n = 1'b1;
          d.a0 = 1'b0;
          d.dout = beat_wdata;
        end
        if (invert) begin
          d.dout = ~d.dout;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: ebt_pkg::S_IDLE, kind: ebt_pkg::K_ROM, rom_sel_n: ebt_pkg::SEL_IDLE,
             lane_n: ebt_pkg::LANE_IDLE, rd_n: 1'b1, wr_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1,
             memr_n: 1'b1, memw_n: 1'b1, pcs_n: 1'b1, shb_n: 1'b1, boe: 1'b1,
             grant_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready = q.ready;
  assign beat_done = q.beat;
  assign beat_rdata = q.rdata;
  assign access_done = q.done;
  assign cmd_bus_error = q.rd_err;
  assign write_error_flag = q.wr_err;
  assign maskable_irq_line_zero = q.wr_err;
  assign ext_addr = q.addr;
  assign data_out = q.dout;
  assign data_oe = q.doe;
  assign bus_oe = q.boe;
  assign rom_select_n = q.rom_sel_n;
  assign rd_n = q.rd_n;
  assign wr_n = q.wr_n;
  assign ior_n = q.ior_n;
  assign iow_n = q.iow_n;
  assign memr_n = q.memr_n;
  assign memw_n = q.memw_n;
  assign panel_chip_select_n = q.pcs_n;
  assign high_byte_enable_n = q.shb_n;
  assign address_bit_zero = q.a0;
  assign lane3_strobe_n = q.lane_n[3];
  assign lane2_strobe_n = q.lane_n[2];
  assign lane1_strobe_n = q.lane_n[1];
  assign lane0_strobe_n = q.lane_n[0];
  assign hold_grant_n = q.grant_n;

endmodule

// *** verification/ebt_far_model.sv ***
// Far-side model: ROM, system bus targets and panel controller
`timescale 1ns/1ps
module ebt_far_model (
  input wire logic sys_clk, rst_n, stall,
  input wire logic [25:0] ext_addr,
  input wire logic rd_n, ior_n, iow_n, memr_n, memw_n,
  output logic [31:0] data_in,
  output logic iochrdy, iocs16_n, memcs16_n, zero_wait_n
);
  logic [31:0] junk_q;
  logic rd_act;
  assign rd_act = !rd_n || !ior_n || !memr_n;
  // Released data lines toggle so a late sample cannot match by luck
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) junk_q <= 32'h0;
    else junk_q <= ~junk_q;
  assign data_in = rd_act ? {2{ext_addr[15:0] ^ 16'h5AC3}} : junk_q;
  assign iochrdy = !stall;
  assign iocs16_n = ior_n && iow_n;
  assign memcs16_n = memr_n && memw_n;
  // Held high for whole periods, never changed mid-period
  assign zero_wait_n = 1'b1;
endmodule

// *** verification/ebt_checker.sv ***
// Concurrent checks on the bus unit ports
`timescale 1ns/1ps
module ebt_checker #(parameter int TIMEOUT_CYCLES = 40) (
  input wire logic sys_clk, rst_n, req_valid, req_ready, access_done, cmd_bus_error,
  input wire logic write_error_flag, maskable_irq_line_zero, error_status_write,
  input wire logic [31:0] error_status_wdata, beat_wdata, data_out,
  input wire logic window_space_select, graphics_mode_bit, flash_write_enable,
  input wire logic hibernate_mode, hold_request_n, hold_grant_n, bus_oe, data_oe,
  input wire logic rd_n, wr_n, iow_n, ior_n, memr_n, memw_n,
  input wire logic high_byte_enable_n, address_bit_zero,
  input wire logic [25:0] ext_addr,
  input wire logic [3:0] rom_select_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int busy_q;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) busy_q <= 0;
    else busy_q <= (req_ready || !hold_grant_n) ? 0 : busy_q + 1;
  lane_pair_a: assert property ((!ior_n || !iow_n || !memr_n || !memw_n) |->
    !(high_byte_enable_n && address_bit_zero)) else $error("odd high byte combination");
  panel_invert_a: assert property (((!wr_n || !memw_n || !iow_n) && data_oe
    && rom_select_n == 4'hF && ext_addr[25:24] == 2'b10 && ext_addr[1:0] == 2'b00
    && !window_space_select && !graphics_mode_bit) |-> data_out[15:0] == ~beat_wdata[15:0])
    else $error("panel data not inverted");
  rom_nowrite_a: assert property ((rom_select_n != 4'hF && !flash_write_enable) |-> wr_n)
    else $error("rom write strobe outside flash");
  grant_float_a: assert property (!hold_grant_n |-> !bus_oe)
    else $error("bus driven while granted");
  hibernate_hold_a: assert property ($fell(hold_grant_n) |-> !$past(hibernate_mode))
    else $error("grant in hibernate");
  grant_take_a: assert property ($fell(hold_request_n) && req_ready && !hibernate_mode
    |-> ##[1:6] !hold_grant_n) else $error("hold not granted");
  grant_release_a: assert property ($rose(hold_request_n) && !hold_grant_n
    |-> ##[1:6] (hold_grant_n && bus_oe)) else $error("hold not released");
  error_pair_a: assert property (cmd_bus_error |-> access_done)
    else $error("bus error without done");
  irq_mirror_a: assert property (maskable_irq_line_zero == write_error_flag)
    else $error("irq differs from flag");
  flag_clear_a: assert property (error_status_write && error_status_wdata[1] && req_ready
    && !req_valid |=> !write_error_flag) else $error("flag not cleared");
  flag_hold_a: assert property (write_error_flag && !(error_status_write
    && error_status_wdata[1]) |=> write_error_flag) else $error("flag dropped");
  deadlock_bound_a: assert property (busy_q < TIMEOUT_CYCLES + 120)
    else $error("access never ended");
  rom_strobe_a: assert property ($fell(rd_n) && rom_select_n != 4'hF && !flash_write_enable
    |=> !rd_n && rom_select_n != 4'hF) else $error("rom strobe too short");
endmodule

// *** verification/ebt_bus_unit_test.sv ***
// Self-checking bench for the external bus timing unit
`timescale 1ns/1ps
module ebt_bus_unit_test;
  localparam int TMO = 40;
  logic sys_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, error_status_write = 0;
  logic [31:0] req_addr = '0, beat_wdata = '0, error_status_wdata = '0;
  logic [31:0] data_in, beat_rdata, data_out, rd, dq, w, ra;
  logic [4:0] req_size = 5'h04;
  logic window_space_select = 0, graphics_mode_bit = 0, panel_wide_bus_enable = 0;
  logic wide_data_bus_mode = 0, flash_write_enable = 0, page_read_select = 0;
  logic hibernate_mode = 0, hold_request_n = 1, stall = 0;
  logic [2:0] rom_wait_field = '0, sysbus_wait_field = '0, fastbus_wait_field = '0;
  logic [1:0] page_wait_field = '0;
  logic iochrdy, iocs16_n, memcs16_n, zero_wait_n, req_ready, beat_done, access_done;
  logic cmd_bus_error, write_error_flag, maskable_irq_line_zero, data_oe, bus_oe;
  logic rd_n, wr_n, ior_n, iow_n, memr_n, memw_n, panel_chip_select_n, hold_grant_n;
  logic high_byte_enable_n, address_bit_zero, lane3_strobe_n, lane2_strobe_n;
  logic lane1_strobe_n, lane0_strobe_n, seen_err, seen_wr, seen_sel;
  logic [25:0] ext_addr;
  logic [3:0] rom_select_n;
  int err_count = 0, checked = 0, n, prev;
  int sz[6] = '{1, 2, 3, 4, 8, 16};
  int bt[6] = '{1, 1, 2, 2, 4, 8};
  ebt_bus_unit #(.TIMEOUT_CYCLES(TMO)) i_ebt_bus_unit (.*);
  ebt_far_model i_ebt_far_model (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic ck(input bit ok, input string m);
    checked++;
    if (!ok) begin
      $display("[FAIL] %0t %s", $time, m);
      err_count++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // n counts edges from the taking edge to the done sample
  task automatic acc(input logic [31:0] a, input logic wr, input logic [4:0] s,
                     input logic [31:0] d);
    {req_addr, req_write, req_size, beat_wdata, req_valid} <= {a, wr, s, d, 1'b1};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    {n, seen_err, seen_wr, seen_sel} = '0;
    while (access_done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
      if (cmd_bus_error === 1'b1) seen_err = 1;
      if (wr_n === 1'b0 || iow_n === 1'b0 || memw_n === 1'b0) {seen_wr, dq} = {1'b1, data_out};
      if (panel_chip_select_n === 1'b0) seen_sel = 1;
      if (beat_done === 1'b1) rd = beat_rdata;
    end
    if (n >= 3000) begin
      ck(0, "request hang");
      wrap_up;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h81E86C7B));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int c = 0; c < 8; c++) begin
      rom_wait_field <= 3'(c);
      ra = 32'h1E000000 + 32'($urandom_range(255) * 4);
      acc(ra, 1'b0, 5'h04, '0);
      ck(n == 2 * (9 - c) + 1, "rom period");
      ck(rd[31:16] === ((ra[15:0] + 16'h0002) ^ 16'h5AC3), "rom data");
    end
    for (int i = 0; i < 6; i++) begin
      acc(32'h1E000000, 1'b0, 5'(sz[i]), '0);
      ck(n == bt[i] * 2 + 1, "rom size");
    end
    {page_read_select, page_wait_field} <= 3'h6;
    acc(32'h1E000000, 1'b0, 5'h08, '0);
    ck(n == 6, "page period");
    flash_write_enable <= 1'b1;
    for (int c = 0; c < 8; c += 7) begin
      rom_wait_field <= 3'(c);
      acc(32'h1E000000, 1'b1, 5'h02, 32'h00001234);
      ck(seen_wr && (c == 0 || n == prev), "flash write");
      prev = n;
    end
    flash_write_enable <= 1'b0;
    acc(32'h1E000000, 1'b1, 5'h02, 32'h00001234);
    ck(!seen_wr, "rom write strobed");
    for (int c = 0; c < 6; c++) begin
      sysbus_wait_field <= 3'(c);
      acc(32'h14000000, 1'b0, 5'h02, '0);
      ck((c == 0 || n < prev) && n > 2 * (8 - c), "sysbus period");
      ck(rd[15:0] === 16'h5AC3, "sysbus data");
      prev = n;
    end
    acc(32'h14000001, 1'b1, 5'h01, 32'h0000AB00);
    ck(dq[7:0] === 8'hAB, "odd byte copy");
    for (int c = 0; c < 4; c++) begin
      fastbus_wait_field <= 3'(c);
      acc(32'h0A000000, 1'b0, 5'h02, '0);
      ck(rd[15:0] === 16'hA53C && (c == 0 || n < prev), "panel read");
      prev = n;
    end
    for (int g = 0; g < 3; g++) begin
      {window_space_select, graphics_mode_bit} <= {g == 2, g == 1};
      w = $urandom;
      acc(32'h0A000000, 1'b1, 5'h02, w);
      ck(dq[15:0] === (g == 0 ? ~w[15:0] : w[15:0]), "panel write");
    end
    ck(seen_sel, "fast window select");
    {window_space_select, graphics_mode_bit, stall} <= 3'h1;
    acc(32'h0A000000, 1'b0, 5'h02, '0);
    ck(seen_err && n > TMO && n < TMO + 40, "deadlock read");
    acc(32'h0A000000, 1'b1, 5'h02, '0);
    ck(write_error_flag === 1'b1, "deadlock write");
    stall <= 1'b0;
    foreach (sz[i]) if (i < 4) begin
      ra = i[1] ? (i[0] ? 32'h0FFFFFFF : 32'h0C000000) : (i[0] ? 32'h09FFFFFF : 32'h04000000);
      acc(ra, 1'b0, 5'h01, '0);
      ck(seen_err && n == 1, "reserved read");
    end
    for (int k = 1; k < 3; k++) begin
      error_status_wdata <= 32'(k);
      error_status_write <= 1'b1;
      @(posedge sys_clk);
      error_status_write <= 1'b0;
      repeat (2) @(posedge sys_clk);
      ck(write_error_flag === (k == 1), "flag clear");
    end
    acc(32'h0C000000, 1'b1, 5'h01, '0);
    ck(write_error_flag === 1'b1 && !seen_err, "reserved write");
    hold_request_n <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hold_grant_n !== 1'b0 && n < 8);
    ck(hold_grant_n === 1'b0 && bus_oe === 1'b0, "hold grant");
    hold_request_n <= 1'b1;
    acc(32'h1E000000, 1'b0, 5'h02, '0);
    ck(n == 3 && hold_grant_n === 1'b1 && bus_oe === 1'b1, "resume");
    {hibernate_mode, hold_request_n} <= 2'h2;
    repeat (12) @(posedge sys_clk);
    ck(hold_grant_n === 1'b1, "hibernate hold");
    {hibernate_mode, hold_request_n} <= 2'h1;
    repeat (4) @(posedge sys_clk);
    wrap_up;
  end
endmodule
bind ebt_bus_unit ebt_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_ebt_checker (.*);
